// file: ssq_pkg.sv
package ssq_pkg;
    localparam int CLK_MHZ = 200;
    localparam int NUM_IN = 10;
    localparam int NUM_CH = 12;
    localparam int NUM_STATES = 63;
    localparam int AVG_PASSES = 16;
    localparam int LOAD_US = 20;
    localparam int LOAD_CYC = LOAD_US * CLK_MHZ;
    localparam int TICK_US = 10;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int TMO_UNIT_US = 100;
    localparam int TMO_TICKS = TMO_UNIT_US / TICK_US;
    localparam int CONV_US = 500;
    localparam int CONV_CYC = CONV_US * CLK_MHZ;
    // state definition word layout
    localparam int DEF_W = 96;
    localparam int F_DRV = 0;
    localparam int F_SEQ_SEL = 10;
    localparam int F_SEQ_LVL = 14;
    localparam int F_SEQ_NEXT = 15;
    localparam int F_SEQ_DLY = 21;
    localparam int F_TMO_NEXT = 37;
    localparam int F_TMO_DLY = 43;
    localparam int F_MON_NEXT = 55;
    localparam int F_MON_MASK = 61;
    localparam int F_MON_WARN = 71;
    localparam int F_LATCH_EN = 72;
    localparam int F_ADC_ON = 73;
    localparam logic [3:0] SEL_WARN = 4'hA;
    // register byte offsets, block numbers and bit positions
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_CHSEL = 12'h004;
    localparam logic [11:0] A_JUMP = 12'h008;
    localparam logic [11:0] A_WALK = 12'h00C;
    localparam logic [11:0] A_FLT_LO = 12'h010;
    localparam logic [11:0] A_FLT_HI = 12'h014;
    localparam logic [11:0] A_STAT_UV = 12'h018;
    localparam logic [11:0] A_STAT_OV = 12'h01C;
    localparam logic [11:0] A_STAT_WARN = 12'h020;
    localparam logic [11:0] A_STORE_PTR = 12'h024;
    localparam logic [11:0] A_STORE_DATA = 12'h028;
    localparam logic [5:0] A_LIMIT_BLK = 6'h01;
    localparam logic [5:0] A_RESULT_BLK = 6'h02;
    localparam int C_RUN = 0;
    localparam int C_CONT = 1;
    localparam int C_AVG = 2;
    localparam int L_MAX = 12;
    localparam int L_EN = 13;
    typedef enum logic {WK_LOAD, WK_RUN} ssq_walk_t;
    typedef enum logic {AD_IDLE, AD_CONV} ssq_adc_t;
endpackage

// file: ssq_top.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - sequence exit on input level after delay
// - input change restarts sequence delay timer
// - monitor exit is wide OR, no delay
// - every exit reloads definition, about 20us
// - timeout exit when condition unmet after delay
// - one latched fault bit per input
// - latch enable per state, disabled keeps bits
// - host reads latched fault bits
// - live undervoltage, overvoltage, limit status
// - twelve converter channels, selected subset
// - single pass or continuous round-robin
// - averaging runs 16 loops, commits at end
// - results are 12-bit unsigned codes
// - one limit per channel, max or min
// - limit violation raises readable warning
// - round-robin starts by host or state
// - each conversion takes about 500us
// - all warnings ORed into one signal
// - host jump forces move to next state
// - up to 63 states, fixed outputs
module ssq_top #(
    parameter int CONV_CYCLES = ssq_pkg::CONV_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] uv_flag,
    input wire logic [9:0] ov_flag,
    input wire logic [9:0] sec_warn,
    input wire logic [11:0] adc_code,
    output logic adc_start,
    output logic [3:0] adc_chan,
    output logic [9:0] driver_outputs,
    output logic warning
);
    typedef struct packed {
        ssq_pkg::ssq_walk_t wk;
        logic [5:0] cur;
        logic [5:0] nxt;
        logic [11:0] ld_cnt;
        logic [95:0] def;
        logic [10:0] seq_div;
        logic [15:0] seq_cnt;
        logic [10:0] tmo_div;
        logic [15:0] tmo_cnt;
        logic sel_prev;
        logic jump_pend;
        logic [9:0] flt;
        logic [2:0] ctrl;
        logic [11:0] chsel;
        logic [9:0] ptr;
        logic [31:0] prdata;
        ssq_pkg::ssq_adc_t ad;
        logic [3:0] ch;
        logic [3:0] pass;
        logic [16:0] conv_cnt;
        logic start;
        logic [11:0][15:0] acc;
        logic [11:0][11:0] res;
        logic [11:0][13:0] lim;
    } ssq_state_t;

    ssq_state_t s_q, s_d;
    logic [95:0] store_mem [0:62];
    logic [95:0] mem_rd;
    logic [9:0] fault, ok_vec;
    logic [11:0] adc_warn;
    logic sel_val, seq_hit, tmo_hit, mon_hit, do_wr, do_setup;
    logic [31:0] rdv;
    logic rd_err;

    // lowest selected channel at or above lo; msb flags a hit
    function automatic logic [4:0] first_from(input logic [11:0] sel, input logic [4:0] lo);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 11; i >= 0; i--) begin
            if (sel[i] && 5'(i) >= lo) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic limit_hit(input logic [13:0] lim, input logic [11:0] res);
        return lim[ssq_pkg::L_EN] && (lim[ssq_pkg::L_MAX] ? (res > lim[11:0])
                                                          : (res < lim[11:0]));
    endfunction

    assign fault = uv_flag | ov_flag;
    assign ok_vec = ~fault;
    always_comb begin
        for (int i = 0; i < ssq_pkg::NUM_CH; i++) begin
            adc_warn[i] = limit_hit(s_q.lim[i], s_q.res[i]);
        end
    end
    assign warning = (|adc_warn) | (|sec_warn);
    assign mem_rd = (s_q.nxt < 6'(ssq_pkg::NUM_STATES)) ? store_mem[s_q.nxt] : '0;
    assign do_wr = psel && penable && pwrite;
    assign do_setup = psel && !penable;
    assign pready = penable;
    assign prdata = s_q.prdata;
    assign driver_outputs = s_q.def[ssq_pkg::F_DRV +: 10];
    assign adc_start = s_q.start;
    assign adc_chan = s_q.ch;

    always_comb begin
        logic [3:0] sel;
        sel = s_q.def[ssq_pkg::F_SEQ_SEL +: 4];
        if (sel == ssq_pkg::SEL_WARN) begin
            sel_val = warning;
        end else if (sel < 4'(ssq_pkg::NUM_IN)) begin
            sel_val = ok_vec[sel];
        end else begin
            sel_val = 1'b0;
        end
    end

    logic seq_cond;
    assign seq_cond = (sel_val == s_q.def[ssq_pkg::F_SEQ_LVL]);
    assign seq_hit = s_q.jump_pend || (seq_cond && (s_q.seq_cnt >=
                     s_q.def[ssq_pkg::F_SEQ_DLY +: 16]));
    assign tmo_hit = (s_q.def[ssq_pkg::F_TMO_DLY +: 12] != 12'h000) && !seq_cond &&
                     (s_q.tmo_cnt >= 16'(s_q.def[ssq_pkg::F_TMO_DLY +: 12] *
                                         ssq_pkg::TMO_TICKS));
    assign mon_hit = (|(s_q.def[ssq_pkg::F_MON_MASK +: 10] & fault)) ||
                     (s_q.def[ssq_pkg::F_MON_WARN] && warning);

    // register read decode
    always_comb begin
        rdv = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr[11:6] == ssq_pkg::A_LIMIT_BLK && paddr[5:2] < 4'(ssq_pkg::NUM_CH)) begin
            rdv = {18'h0_0000, s_q.lim[paddr[5:2]]};
        end else if (paddr[11:6] == ssq_pkg::A_RESULT_BLK &&
                     paddr[5:2] < 4'(ssq_pkg::NUM_CH)) begin
            rdv = {20'h0_0000, s_q.res[paddr[5:2]]};
        end else if (paddr == ssq_pkg::A_CTRL) begin
            rdv = {23'h00_0000, s_q.ad == ssq_pkg::AD_CONV, 5'h00, s_q.ctrl};
        end else if (paddr == ssq_pkg::A_CHSEL) begin
            rdv = {20'h0_0000, s_q.chsel};
        end else if (paddr == ssq_pkg::A_JUMP) begin
            rdv = {31'h0000_0000, s_q.jump_pend};
        end else if (paddr == ssq_pkg::A_WALK) begin
            rdv = {14'h0000, driver_outputs, 1'b0, s_q.wk == ssq_pkg::WK_LOAD, s_q.cur};
        end else if (paddr == ssq_pkg::A_FLT_LO) begin
            rdv = {24'h00_0000, s_q.flt[7:0]};
        end else if (paddr == ssq_pkg::A_FLT_HI) begin
            rdv = {30'h0000_0000, s_q.flt[9:8]};
        end else if (paddr == ssq_pkg::A_STAT_UV) begin
            rdv = {22'h00_0000, uv_flag};
        end else if (paddr == ssq_pkg::A_STAT_OV) begin
            rdv = {22'h00_0000, ov_flag};
        end else if (paddr == ssq_pkg::A_STAT_WARN) begin
            rdv = {20'h0_0000, adc_warn};
        end else if (paddr == ssq_pkg::A_STORE_PTR) begin
            rdv = {22'h00_0000, s_q.ptr};
        end else if (paddr != ssq_pkg::A_STORE_DATA) begin
            rd_err = 1'b1;
        end
    end
    assign pslverr = psel && penable && rd_err;

    always_comb begin
        logic [4:0] f;
        logic [9:0] clr;
        logic exit;
        f = 5'h00;
        clr = 10'h000;
        exit = 1'b0;
        s_d = s_q;
        s_d.start = 1'b0;
        if (do_setup) begin
            s_d.prdata = rdv;
        end
        // state walker
        if (s_q.wk == ssq_pkg::WK_LOAD) begin
            s_d.ld_cnt = s_q.ld_cnt + 12'h001;
            if (s_q.ld_cnt == 12'(ssq_pkg::LOAD_CYC - 1)) begin
                s_d.wk = ssq_pkg::WK_RUN;
                s_d.def = mem_rd;
                s_d.cur = s_q.nxt;
                s_d.seq_div = '0;
                s_d.seq_cnt = '0;
                s_d.tmo_div = '0;
                s_d.tmo_cnt = '0;
                s_d.sel_prev = 1'b0;
                if (mem_rd[ssq_pkg::F_ADC_ON]) begin
                    s_d.ctrl[ssq_pkg::C_RUN] = 1'b1;
                end
            end
        end else begin
            s_d.sel_prev = sel_val;
            if (sel_val != s_q.sel_prev || !seq_cond) begin
                s_d.seq_div = '0;
                s_d.seq_cnt = '0;
            end else if (s_q.seq_div == 11'(ssq_pkg::TICK_CYC - 1)) begin
                s_d.seq_div = '0;
                if (s_q.seq_cnt != 16'hFFFF) begin
                    s_d.seq_cnt = s_q.seq_cnt + 16'h0001;
                end
            end else begin
                s_d.seq_div = s_q.seq_div + 11'h001;
            end
            if (s_q.tmo_div == 11'(ssq_pkg::TICK_CYC - 1)) begin
                s_d.tmo_div = '0;
                if (s_q.tmo_cnt != 16'hFFFF) begin
                    s_d.tmo_cnt = s_q.tmo_cnt + 16'h0001;
                end
            end else begin
                s_d.tmo_div = s_q.tmo_div + 11'h001;
            end
            exit = 1'b1;
            if (mon_hit) begin
                s_d.nxt = s_q.def[ssq_pkg::F_MON_NEXT +: 6];
            end else if (tmo_hit) begin
                s_d.nxt = s_q.def[ssq_pkg::F_TMO_NEXT +: 6];
            end else if (seq_hit) begin
                s_d.nxt = s_q.def[ssq_pkg::F_SEQ_NEXT +: 6];
            end else begin
                exit = 1'b0;
            end
            if (exit) begin
                s_d.wk = ssq_pkg::WK_LOAD;
                s_d.ld_cnt = '0;
                s_d.jump_pend = 1'b0;
            end
        end
        // round-robin scheduler
        if (s_q.ad == ssq_pkg::AD_IDLE) begin
            f = first_from(s_q.chsel, 5'h00);
            if (s_q.ctrl[ssq_pkg::C_RUN] && f[4]) begin
                s_d.ad = ssq_pkg::AD_CONV;
                s_d.ch = f[3:0];
                s_d.pass = '0;
                s_d.conv_cnt = '0;
                s_d.start = 1'b1;
            end
        end else if (s_q.conv_cnt != 17'(CONV_CYCLES - 1)) begin
            s_d.conv_cnt = s_q.conv_cnt + 17'h0_0001;
        end else begin
            s_d.conv_cnt = '0;
            if (s_q.ctrl[ssq_pkg::C_AVG]) begin
                s_d.acc[s_q.ch] = ((s_q.pass == 4'h0) ? 16'h0000 : s_q.acc[s_q.ch]) +
                                  {4'h0, adc_code};
            end else begin
                s_d.res[s_q.ch] = adc_code;
            end
            f = first_from(s_q.chsel, 5'(s_q.ch) + 5'h01);
            if (f[4]) begin
                s_d.ch = f[3:0];
                s_d.start = 1'b1;
            end else if (s_q.ctrl[ssq_pkg::C_AVG] &&
                         s_q.pass != 4'(ssq_pkg::AVG_PASSES - 1)) begin
                s_d.pass = s_q.pass + 4'h1;
                f = first_from(s_q.chsel, 5'h00);
                s_d.ch = f[3:0];
                s_d.start = 1'b1;
            end else begin
                if (s_q.ctrl[ssq_pkg::C_AVG]) begin
                    for (int i = 0; i < ssq_pkg::NUM_CH; i++) begin
                        if (s_q.chsel[i]) begin
                            s_d.res[i] = s_d.acc[i][15:4];
                        end
                    end
                end
                f = first_from(s_q.chsel, 5'h00);
                s_d.pass = '0;
                if (s_q.ctrl[ssq_pkg::C_CONT] && s_q.ctrl[ssq_pkg::C_RUN] && f[4]) begin
                    s_d.ch = f[3:0];
                    s_d.start = 1'b1;
                end else begin
                    s_d.ad = ssq_pkg::AD_IDLE;
                    s_d.ctrl[ssq_pkg::C_RUN] = 1'b0;
                end
            end
        end
        // host writes come last so a host set beats a hardware clear
        if (do_wr) begin
            if (paddr[11:6] == ssq_pkg::A_LIMIT_BLK && paddr[5:2] < 4'(ssq_pkg::NUM_CH)) begin
                s_d.lim[paddr[5:2]] = pwdata[13:0];
            end else if (paddr == ssq_pkg::A_CTRL) begin
                s_d.ctrl = pwdata[2:0];
            end else if (paddr == ssq_pkg::A_CHSEL) begin
                s_d.chsel = pwdata[11:0];
            end else if (paddr == ssq_pkg::A_JUMP) begin
                if (pwdata[0]) begin
                    s_d.jump_pend = 1'b1;
                end
            end else if (paddr == ssq_pkg::A_FLT_LO) begin
                clr[7:0] = pwdata[7:0];
            end else if (paddr == ssq_pkg::A_FLT_HI) begin
                clr[9:8] = pwdata[1:0];
            end else if (paddr == ssq_pkg::A_STORE_PTR) begin
                s_d.ptr = pwdata[9:0];
            end
        end
        // cleared bits give way to faults seen in the same cycle
        s_d.flt = s_q.flt & ~clr;
        if (s_q.wk == ssq_pkg::WK_RUN && s_q.def[ssq_pkg::F_LATCH_EN]) begin
            s_d.flt = s_d.flt | fault;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // definition store, no reset: it stands in for nonvolatile memory
    always_ff @(posedge pclk) begin
        if (do_wr && paddr == ssq_pkg::A_STORE_DATA && s_q.ptr[5:0] < 6'(ssq_pkg::NUM_STATES)) begin
            case (s_q.ptr[9:8])
                2'h0: store_mem[s_q.ptr[5:0]][31:0] <= pwdata;
                2'h1: store_mem[s_q.ptr[5:0]][63:32] <= pwdata;
                default: store_mem[s_q.ptr[5:0]][95:64] <= pwdata;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_run_exit;
        s_q.wk == ssq_pkg::WK_RUN && (mon_hit || tmo_hit || seq_hit);
    endsequence
    sequence s_load_end;
        s_q.wk == ssq_pkg::WK_LOAD && s_q.ld_cnt == 12'(ssq_pkg::LOAD_CYC - 1);
    endsequence

    a_mon_first: assert property (s_q.wk == ssq_pkg::WK_RUN && mon_hit |=>
        s_q.wk == ssq_pkg::WK_LOAD && s_q.nxt == $past(s_q.def[ssq_pkg::F_MON_NEXT +: 6]))
        else $error("monitor exit not taken");
    a_tmo_over_seq: assert property (s_q.wk == ssq_pkg::WK_RUN && !mon_hit && tmo_hit |=>
        s_q.nxt == $past(s_q.def[ssq_pkg::F_TMO_NEXT +: 6]))
        else $error("timeout exit priority wrong");
    a_exit_loads: assert property (s_run_exit |=> s_q.wk == ssq_pkg::WK_LOAD &&
        s_q.ld_cnt == 12'h000) else $error("exit did not start a load");
    a_load_bound: assert property (s_q.wk == ssq_pkg::WK_LOAD |->
        s_q.ld_cnt < 12'(ssq_pkg::LOAD_CYC)) else $error("load ran too long");
    a_timer_clear: assert property (s_load_end |=> s_q.wk == ssq_pkg::WK_RUN &&
        s_q.seq_cnt == 16'h0000 && s_q.tmo_cnt == 16'h0000) else $error("timers not cleared");
    a_seq_restart: assert property (s_q.wk == ssq_pkg::WK_RUN && sel_val != s_q.sel_prev &&
        !(mon_hit || tmo_hit || seq_hit) |=> s_q.seq_cnt == 16'h0000)
        else $error("sequence timer kept running");
    a_drv_stable: assert property (s_q.wk == ssq_pkg::WK_RUN && !$rose(s_q.wk == ssq_pkg::WK_RUN)
        |-> $stable(driver_outputs)) else $error("outputs moved within a state");
    a_flt_hold: assert property (!s_q.def[ssq_pkg::F_LATCH_EN] && !do_wr |=>
        $stable(s_q.flt)) else $error("fault latch changed while disabled");
    a_flt_set: assert property (s_q.wk == ssq_pkg::WK_RUN && s_q.def[ssq_pkg::F_LATCH_EN] |=>
        (s_q.flt & $past(fault)) == $past(fault)) else $error("fault bit not latched");
    a_jump_exit: assert property (s_q.wk == ssq_pkg::WK_RUN && s_q.jump_pend && !mon_hit &&
        !tmo_hit |=> s_q.nxt == $past(s_q.def[ssq_pkg::F_SEQ_NEXT +: 6]))
        else $error("jump ignored");
    a_start_pulse: assert property (s_q.start |=> !s_q.start [*2])
        else $error("conversion restarted too soon");
    a_avg_hold: assert property (s_q.ad == ssq_pkg::AD_CONV && s_q.ctrl[ssq_pkg::C_AVG] &&
        s_q.pass != 4'(ssq_pkg::AVG_PASSES - 1) && !do_wr |=> $stable(s_q.res))
        else $error("average result written early");
endmodule

// file: ssq_far_side.sv
`timescale 1ns/1ps
// converter front end: code is held only for one conversion, then inverted
module ssq_far_side #(
    parameter int CONV_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic adc_start,
    input wire logic [3:0] adc_chan,
    output logic [11:0] adc_code
);
    int cnt_q;
    logic [7:0] starts_q;
    logic [11:0] code_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
            starts_q <= 8'h00;
            code_q <= 12'h000;
        end else if (adc_start) begin
            cnt_q <= CONV_CYCLES + 1;
            starts_q <= starts_q + 8'h01;
            // every other pass per channel reads 2 higher, so averaging shows
            code_q <= {adc_chan, 8'hA0} + {10'h000, starts_q[1], 1'b0};
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign adc_code = (cnt_q > 0) ? code_q : ~code_q;
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_start, warning;
    logic [11:0] paddr, adc_code;
    logic [31:0] pwdata, prdata, r;
    logic [9:0] uv_flag, ov_flag, sec_warn, driver_outputs;
    logic [3:0] adc_chan;
    int n_errors = 0, checked = 0, cyc = 0, n_starts = 0, t;

    ssq_top #(.CONV_CYCLES(20)) ssq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .uv_flag(uv_flag), .ov_flag(ov_flag),
        .sec_warn(sec_warn), .adc_code(adc_code), .adc_start(adc_start), .adc_chan(adc_chan),
        .driver_outputs(driver_outputs), .warning(warning));
    ssq_far_side #(.CONV_CYCLES(20)) ssq_far_side_inst (.pclk(pclk), .presetn(presetn),
        .adc_start(adc_start), .adc_chan(adc_chan), .adc_code(adc_code));

    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end

    task results();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (adc_start === 1'b1) n_starts++;
        if (cyc == 60000) begin
            n_errors++;
            results();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask

    task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic e;
        apb(1'b0, a, 32'h0, e);
        chk(nm, exp, r);
    endtask

    task wait_drv(input logic [9:0] exp, input int lim);
        t = 0;
        while (driver_outputs !== exp && t < lim) begin
            @(posedge pclk);
            t++;
        end
        chk("driver_outputs", {22'h0, exp}, {22'h0, driver_outputs});
    endtask

    function automatic logic [95:0] mkdef(logic [9:0] drv, logic [3:0] sel, logic lvl,
        logic [5:0] sn, logic [15:0] sd, logic [5:0] tn, logic [11:0] td, logic [5:0] mn,
        logic [9:0] mm, logic le);
        logic [95:0] d;
        d = '0;
        d[ssq_pkg::F_DRV +: 10] = drv;
        d[ssq_pkg::F_SEQ_SEL +: 4] = sel;
        d[ssq_pkg::F_SEQ_LVL] = lvl;
        d[ssq_pkg::F_SEQ_NEXT +: 6] = sn;
        d[ssq_pkg::F_SEQ_DLY +: 16] = sd;
        d[ssq_pkg::F_TMO_NEXT +: 6] = tn;
        d[ssq_pkg::F_TMO_DLY +: 12] = td;
        d[ssq_pkg::F_MON_NEXT +: 6] = mn;
        d[ssq_pkg::F_MON_MASK +: 10] = mm;
        d[ssq_pkg::F_LATCH_EN] = le;
        return d;
    endfunction

    task store(input logic [5:0] st, input logic [95:0] d);
        for (int w = 0; w < 3; w++) begin
            wr(ssq_pkg::A_STORE_PTR, {22'h0, w[1:0], 2'b00, st});
            wr(ssq_pkg::A_STORE_DATA, d[32 * w +: 32]);
        end
    endtask

    initial begin
        logic e;
        presetn = 0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0;
        uv_flag = 10'h001;
        ov_flag = 10'h000;
        sec_warn = 10'h000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // store is not reset, so all states go in during the first load
        store(6'h00, mkdef(10'h001, 4'h0, 1'b1, 6'h01, 16'h0001, 6'h0, 12'h0, 6'h0, 10'h0, 1'b0));
        store(6'h01, mkdef(10'h002, 4'hA, 1'b1, 6'h03, 16'h0, 6'h03, 12'h001, 6'h02, 10'h204,
            1'b1));
        store(6'h02, mkdef(10'h3FF, 4'h0, 1'b0, 6'h03, 16'h0, 6'h0, 12'h0, 6'h0, 10'h0, 1'b0));
        store(6'h03, mkdef(10'h155, 4'h1, 1'b0, 6'h00, 16'h0, 6'h02, 12'h001, 6'h0, 10'h0, 1'b0));
        apb(1'b0, 12'h030, 32'h0, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        rd("walk loading", ssq_pkg::A_WALK, 32'h40);
        wait_drv(10'h001, 5000);
        uv_flag <= 10'h000;
        repeat (1000) @(posedge pclk);
        uv_flag <= 10'h001;
        @(posedge pclk);
        uv_flag <= 10'h000;
        repeat (1500) @(posedge pclk);
        rd("walk restarted", ssq_pkg::A_WALK, 32'h100);
        repeat (800) @(posedge pclk);
        rd("walk exit", ssq_pkg::A_WALK, 32'h140);
        wait_drv(10'h002, 4500);
        chk("load latency", 1, {31'h0, t > 3500 && t < 3900});
        uv_flag <= 10'h004;
        ov_flag <= 10'h200;
        sec_warn <= 10'h001;
        @(posedge pclk);
        @(negedge pclk);
        chk("warning", 32'h1, {31'h0, warning});
        wait_drv(10'h3FF, 4100);
        sec_warn <= 10'h000;
        uv_flag <= 10'h024;
        repeat (4) @(posedge pclk);
        rd("latch low", ssq_pkg::A_FLT_LO, 32'h004);
        rd("latch high", ssq_pkg::A_FLT_HI, 32'h002);
        rd("live uv", ssq_pkg::A_STAT_UV, 32'h024);
        rd("live ov", ssq_pkg::A_STAT_OV, 32'h200);
        uv_flag <= 10'h000;
        ov_flag <= 10'h000;
        wr(ssq_pkg::A_FLT_LO, 32'h004);
        rd("latch cleared", ssq_pkg::A_FLT_LO, 32'h000);
        rd("live uv clear", ssq_pkg::A_STAT_UV, 32'h000);
        wr(ssq_pkg::A_JUMP, 32'h1);
        wait_drv(10'h155, 4100);
        wait_drv(10'h3FF, 24400);
        chk("timeout span", 1, {31'h0, t > 21900});
        wr(12'h040, 32'h2100);
        wr(12'h06C, 32'h3C00);
        wr(ssq_pkg::A_CHSEL, 32'h801);
        wr(ssq_pkg::A_CTRL, 32'h1);
        repeat (100) @(posedge pclk);
        rd("single done", ssq_pkg::A_CTRL, 32'h0);
        chk("single starts", 32'h2, n_starts);
        rd("result ch0", 12'h080, 32'h0A0);
        rd("result ch11", 12'h0AC, 32'hBA0);
        rd("limit warn", ssq_pkg::A_STAT_WARN, 32'h001);
        chk("warning out", 32'h1, {31'h0, warning});
        wr(ssq_pkg::A_CTRL, 32'h5);
        repeat (200) @(posedge pclk);
        rd("avg pending", 12'h080, 32'h0A0);
        repeat (700) @(posedge pclk);
        rd("avg done", ssq_pkg::A_CTRL, 32'h4);
        rd("avg ch0", 12'h080, 32'h0A1);
        rd("avg ch11", 12'h0AC, 32'hBA1);
        chk("avg starts", 32'd34, n_starts);
        wr(ssq_pkg::A_CTRL, 32'h3);
        repeat (300) @(posedge pclk);
        chk("continuous", 1, {31'h0, n_starts > 44});
        wr(ssq_pkg::A_CTRL, 32'h0);
        results();
    end
endmodule
